// ---- vbuf_i2c_defines.svh ----
// Constants for the video buffer two-wire control block
`ifndef VBUF_I2C_DEFINES_SVH
`define VBUF_I2C_DEFINES_SVH

`define ADDR_PREFIX   5'h0b
`define DIR_READ      1'h1
`define BYTE_BITS     4'h8
`define CNT_ZERO      4'h0
`define CNT_ONE       4'h1

`define SUB_CH1       8'h01
`define SUB_CH2       8'h02
`define SUB_CH3       8'h03
`define SUB_SYNC      8'h04

`define CH_RST_OFF    8'h00
`define CH_RST_ON     8'h04
`define SYNC_RST_OFF  8'h60
`define SYNC_RST_ON   8'h20

`define CH_FILT_BIT   7
`define CH_MUX_HI     6
`define CH_MUX_LO     3
`define CH_MODE_HI    2
`define CH_MODE_LO    0
`define SYNC_MON_DIS  6
`define SYNC_BUF_DIS  5
`define SYNC_V_HI     4
`define SYNC_V_LO     3
`define SYNC_H_HI     2
`define SYNC_H_LO     1
`define SYNC_EN_BIT   0

`define MODE_OFF      3'h0
`define MODE_MUTE     3'h1
`define MODE_STC_LOW  3'h5
`define MUX_B_FIRST   4'h5
`define MUX_B_LAST    4'h9
`define SYNC_SEL_B    2'h1

`endif

// ---- vbuf_i2c_pkg.sv ----
// Types shared by the video buffer two-wire control block
`default_nettype none
package vbuf_i2c_pkg;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_SUB      = 4'h3,
    ST_SUB_ACK  = 4'h4,
    ST_DATA     = 4'h5,
    ST_DATA_ACK = 4'h6,
    ST_RD       = 4'h7,
    ST_RD_ACK   = 4'h8,
    ST_WAIT     = 4'h9
  } link_state_t;

endpackage : vbuf_i2c_pkg
`default_nettype wire

// ---- vbuf_i2c_ctrl.sv ----
// Two-wire slave and channel configuration registers of the video buffer
`timescale 1ns/1ps
`default_nettype none
`include "vbuf_i2c_defines.svh"

module vbuf_i2c_ctrl
  import vbuf_i2c_pkg::*;
(
  // Core clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // Link clock, free running
  input  wire logic       link_clk_i,
  // Two-wire bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Address select and power-up strap pins
  input  wire logic       addr_select_high_pin_i,
  input  wire logic       addr_select_low_pin_i,
  input  wire logic       power_up_state_strap_i,
  // Per-channel controls, bit n is channel n+1; input_mode_o gives channel n+1 bits 3n+2:3n
  output logic [2:0]      monitor_en_o,
  output logic [2:0]      buffer_en_o,
  output logic [2:0]      mute_o,
  output logic [2:0]      mux_input_b_o,
  output logic [2:0]      clamp_filter_wide_o,
  output logic [8:0]      input_mode_o,
  // Sync path controls
  output logic            vsync_input_b_o,
  output logic            hsync_input_b_o,
  output logic            sync_en_o
);

  // ---------------- Link domain ----------------
  logic        rst_meta_l;
  logic        rst_link;
  logic        strap_meta_l;
  logic        strap_sync_l;
  logic        scl_meta;
  logic        scl_sync;
  logic        scl_prev;
  logic        sda_meta;
  logic        sda_sync;
  logic        sda_prev;
  logic        a1_meta;
  logic        a1_sync;
  logic        a0_meta;
  logic        a0_sync;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  link_state_t state_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  wdata_reg;
  logic        dir_reg;
  logic        pend_reg;
  logic        sda_oe_reg;
  logic        sda_out_reg;
  logic        commit;
  logic        wr_tgl_reg;
  logic [7:0]  cfg_link_reg [0:3];
  logic [7:0]  rd_byte;

  always_ff @(posedge link_clk_i) begin
    rst_meta_l   <= reset_i;
    rst_link     <= rst_meta_l;
    strap_meta_l <= power_up_state_strap_i;
    strap_sync_l <= strap_meta_l;
  end

  // Pin synchronisers, then one stage for edge detection on scl and sda
  always_ff @(posedge link_clk_i) begin
    scl_meta <= scl_i;
    scl_sync <= scl_meta;
    scl_prev <= scl_sync;
    sda_meta <= sda_i;
    sda_sync <= sda_meta;
    sda_prev <= sda_sync;
    a1_meta  <= addr_select_high_pin_i;
    a1_sync  <= a1_meta;
    a0_meta  <= addr_select_low_pin_i;
    a0_sync  <= a0_meta;
  end

  assign scl_rise  = scl_sync & ~scl_prev;
  assign scl_fall  = ~scl_sync & scl_prev;
  assign start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_det  = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign commit = stop_det & pend_reg;
  always_comb begin
    unique case (ptr_reg)
      `SUB_CH1:  rd_byte = cfg_link_reg[0];
      `SUB_CH2:  rd_byte = cfg_link_reg[1];
      `SUB_CH3:  rd_byte = cfg_link_reg[2];
      `SUB_SYNC: rd_byte = cfg_link_reg[3];
      default:   rd_byte = 8'h00;
    endcase
  end

  // Protocol state machine
  always_ff @(posedge link_clk_i) begin
    if (rst_link) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= `CNT_ZERO;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      wdata_reg   <= 8'h00;
      dir_reg     <= 1'b0;
      pend_reg    <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else if (start_det) begin
      state_reg   <= ST_ADDR;
      bit_cnt_reg <= `CNT_ZERO;
      pend_reg    <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else if (stop_det) begin
      state_reg   <= ST_IDLE;
      pend_reg    <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_WAIT: begin
          sda_oe_reg <= 1'b0;
        end
        ST_ADDR, ST_SUB, ST_DATA: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_sync};
            bit_cnt_reg <= bit_cnt_reg + `CNT_ONE;
          end else if (scl_fall && bit_cnt_reg == `BYTE_BITS) begin
            bit_cnt_reg <= `CNT_ZERO;
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == {`ADDR_PREFIX, a1_sync, a0_sync}) begin
                state_reg  <= ST_ADDR_ACK;
                sda_oe_reg <= 1'b1;
                dir_reg    <= shift_reg[0];
              end else begin
                state_reg  <= ST_WAIT;
              end
            end else if (state_reg == ST_SUB) begin
              ptr_reg    <= shift_reg;
              state_reg  <= ST_SUB_ACK;
              sda_oe_reg <= 1'b1;
            end else begin
              wdata_reg  <= shift_reg;
              pend_reg   <= 1'b1;
              state_reg  <= ST_DATA_ACK;
              sda_oe_reg <= 1'b1;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (dir_reg == `DIR_READ) begin
              tx_reg      <= rd_byte;
              sda_oe_reg  <= ~rd_byte[7];
              bit_cnt_reg <= `CNT_ONE;
              state_reg   <= ST_RD;
            end else begin
              sda_oe_reg  <= 1'b0;
              state_reg   <= ST_SUB;
            end
          end
        end
        ST_SUB_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= ST_DATA;
          end
        end
        ST_DATA_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= ST_WAIT;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt_reg == `BYTE_BITS) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_RD_ACK;
            end else begin
              sda_oe_reg  <= ~tx_reg[6];
              tx_reg      <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + `CNT_ONE;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            state_reg <= ST_WAIT;
          end
        end
        default: begin
          state_reg  <= ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Line is open drain: only ever pulled low
  always_ff @(posedge link_clk_i) begin
    sda_out_reg <= 1'b0;
  end
  assign sda_o    = sda_out_reg;
  assign sda_oe_o = sda_oe_reg;
  // Link-side register copy, read back and handed to the core
  always_ff @(posedge link_clk_i) begin
    if (rst_link) begin
      for (int i = 0; i < 3; i++) begin
        cfg_link_reg[i] <= strap_sync_l ? `CH_RST_ON : `CH_RST_OFF;
      end
      cfg_link_reg[3] <= strap_sync_l ? `SYNC_RST_ON : `SYNC_RST_OFF;
      wr_tgl_reg      <= 1'b0;
    end else if (commit) begin
      unique case (ptr_reg)
        `SUB_CH1:  cfg_link_reg[0] <= wdata_reg;
        `SUB_CH2:  cfg_link_reg[1] <= wdata_reg;
        `SUB_CH3:  cfg_link_reg[2] <= wdata_reg;
        `SUB_SYNC: cfg_link_reg[3] <= wdata_reg;
        default:   cfg_link_reg[0] <= cfg_link_reg[0];
      endcase
      wr_tgl_reg <= ~wr_tgl_reg;
    end
  end

  // ---------------- Core domain ----------------
  logic       strap_meta;
  logic       strap_sync;
  logic       tgl_meta;
  logic       tgl_sync;
  logic       tgl_seen;
  logic       wr_evt;
  logic [7:0] cfg_reg  [0:3];
  logic [7:0] cfg_next [0:3];
  logic [2:0] monitor_en_reg;
  logic [2:0] buffer_en_reg;
  logic [2:0] mute_reg;
  logic [2:0] mux_b_reg;
  logic [2:0] filt_reg;
  logic [8:0] mode_reg;
  logic       vsync_b_reg;
  logic       hsync_b_reg;
  logic       sync_en_reg;

  always_ff @(posedge core_clk_i) begin
    strap_meta <= power_up_state_strap_i;
    strap_sync <= strap_meta;
  end

  // Write event crosses as a toggle; link copy is stable long after it
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tgl_meta <= 1'b0;
      tgl_sync <= 1'b0;
      tgl_seen <= 1'b0;
    end else begin
      tgl_meta <= wr_tgl_reg;
      tgl_sync <= tgl_meta;
      tgl_seen <= tgl_sync;
    end
  end
  assign wr_evt = tgl_sync ^ tgl_seen;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (reset_i) begin
        if (i == 3) begin
          cfg_next[i] = strap_sync ? `SYNC_RST_ON : `SYNC_RST_OFF;
        end else begin
          cfg_next[i] = strap_sync ? `CH_RST_ON : `CH_RST_OFF;
        end
      end else if (wr_evt) begin
        cfg_next[i] = cfg_link_reg[i];
      end else begin
        cfg_next[i] = cfg_reg[i];
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 4; i++) begin
      cfg_reg[i] <= cfg_next[i];
    end
  end
  // Decoded channel controls
  always_ff @(posedge core_clk_i) begin
    for (int c = 0; c < 3; c++) begin
      monitor_en_reg[c] <=
        (cfg_next[c][`CH_MODE_HI:`CH_MODE_LO] != `MODE_OFF) &&
        (cfg_next[c][`CH_MODE_HI:`CH_MODE_LO] != `MODE_MUTE) &&
        !cfg_next[3][`SYNC_MON_DIS];
      buffer_en_reg[c] <=
        (cfg_next[c][`CH_MODE_HI:`CH_MODE_LO] != `MODE_OFF) &&
        (cfg_next[c][`CH_MODE_HI:`CH_MODE_LO] != `MODE_MUTE) &&
        !cfg_next[3][`SYNC_BUF_DIS];
      mute_reg[c] <=
        cfg_next[c][`CH_MODE_HI:`CH_MODE_LO] == `MODE_MUTE;
      mux_b_reg[c] <=
        (cfg_next[c][`CH_MUX_HI:`CH_MUX_LO] >= `MUX_B_FIRST) &&
        (cfg_next[c][`CH_MUX_HI:`CH_MUX_LO] <= `MUX_B_LAST);
      filt_reg[c] <= cfg_next[c][`CH_FILT_BIT] &&
        (cfg_next[c][`CH_MODE_HI:`CH_MODE_LO] >= `MODE_STC_LOW);
      mode_reg[3*c +: 3] <= cfg_next[c][`CH_MODE_HI:`CH_MODE_LO];
    end
  end
  always_ff @(posedge core_clk_i) begin
    vsync_b_reg <= cfg_next[3][`SYNC_V_HI:`SYNC_V_LO] == `SYNC_SEL_B;
    hsync_b_reg <= cfg_next[3][`SYNC_H_HI:`SYNC_H_LO] == `SYNC_SEL_B;
    sync_en_reg <= cfg_next[3][`SYNC_EN_BIT];
  end
  assign monitor_en_o        = monitor_en_reg;
  assign buffer_en_o         = buffer_en_reg;
  assign mute_o              = mute_reg;
  assign mux_input_b_o       = mux_b_reg;
  assign clamp_filter_wide_o = filt_reg;
  assign input_mode_o        = mode_reg;
  assign vsync_input_b_o     = vsync_b_reg;
  assign hsync_input_b_o     = hsync_b_reg;
  assign sync_en_o           = sync_en_reg;
  // ---------------- Checks ----------------
  chk_start_restart: assert property (
    @(posedge link_clk_i) disable iff (rst_link)
    start_det |=> (state_reg == ST_ADDR) && (bit_cnt_reg == `CNT_ZERO))
    else $error("start did not restart address phase");
  chk_addr_ack_drive: assert property (
    @(posedge link_clk_i) disable iff (rst_link)
    (state_reg == ST_ADDR_ACK) |-> sda_oe_reg)
    else $error("address acknowledge not driven");
  chk_addr_prefix_match: assert property (
    @(posedge link_clk_i) disable iff (rst_link)
    $rose(state_reg == ST_ADDR_ACK) |->
      shift_reg[7:1] == {`ADDR_PREFIX, a1_sync, a0_sync})
    else $error("acknowledged a foreign address");
  chk_sda_scl_high: assert property (
    @(posedge link_clk_i) disable iff (rst_link)
    (scl_sync && scl_prev) |-> $stable(sda_oe_reg))
    else $error("data changed while clock high");
  chk_stop_idle: assert property (
    @(posedge link_clk_i) disable iff (rst_link)
    stop_det |=> (state_reg == ST_IDLE) && !sda_oe_reg)
    else $error("stop did not free the bus");
  chk_rd_ack_release: assert property (
    @(posedge link_clk_i) disable iff (rst_link)
    (state_reg == ST_RD_ACK) |-> !sda_oe_reg)
    else $error("data held during master acknowledge");
  chk_extra_byte_nack: assert property (
    @(posedge link_clk_i) disable iff (rst_link)
    (state_reg == ST_WAIT) |-> !sda_oe_reg)
    else $error("extra byte was acknowledged");
  chk_commit_load: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    wr_evt |=> cfg_reg[3] == $past(cfg_link_reg[3]))
    else $error("write not taken by core copy");
  chk_master_disable: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    cfg_reg[3][`SYNC_MON_DIS] |=> ##0 (monitor_en_reg == 3'h0) ||
      !cfg_reg[3][`SYNC_MON_DIS])
    else $error("monitor path on under master disable");
  chk_mode_off_paths: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (cfg_reg[0][`CH_MODE_HI:`CH_MODE_LO] == `MODE_OFF) |->
      !monitor_en_reg[0] && !buffer_en_reg[0])
    else $error("channel paths on in off mode");
endmodule : vbuf_i2c_ctrl
`default_nettype wire

// ---- vbuf_i2c_master_model.sv ----
// Behavioural two-wire bus master that drives the control block's pins
`timescale 1ns/1ps
`default_nettype none

module vbuf_i2c_master_model (
  // Link clock paces every bus phase
  input  wire logic       link_clk_i,
  // Data line level as seen on the wire
  input  wire logic       sda_i,
  // Bus drive, 1 on data means released
  output logic            scl_o,
  output logic            sda_o,
  // Byte received by a read
  output logic            rd_valid_o,
  output logic [7:0]      rd_data_o
);
  localparam int HALF = 8;

  initial begin
    scl_o      = 1'b1;
    sda_o      = 1'b1;
    rd_valid_o = 1'b0;
    rd_data_o  = 8'h00;
  end

  task automatic wait_lnk(input int n);
    repeat (n) @(posedge link_clk_i);
  endtask : wait_lnk

  task automatic start_cond;
    sda_o <= 1'b1;
    wait_lnk(HALF);
    scl_o <= 1'b1;
    wait_lnk(HALF);
    sda_o <= 1'b0;
    wait_lnk(HALF);
    scl_o <= 1'b0;
    wait_lnk(HALF);
  endtask : start_cond

  task automatic stop_cond;
    sda_o <= 1'b0;
    wait_lnk(HALF);
    scl_o <= 1'b1;
    wait_lnk(HALF);
    sda_o <= 1'b1;
    wait_lnk(HALF);
  endtask : stop_cond

  // Data moves only while the clock is low; short hold after the fall
  task automatic bit_xfer(input logic b, output logic s);
    sda_o <= b;
    wait_lnk(HALF);
    scl_o <= 1'b1;
    wait_lnk(HALF / 2);
    s = sda_i;
    wait_lnk(HALF / 2);
    scl_o <= 1'b0;
    wait_lnk(2);
  endtask : bit_xfer

  // Nine-bit unit, data released for the acknowledge clock
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    ack = !s;
  endtask : send_byte

  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(nack, s);
  endtask : recv_byte

  // One subaddress byte and one data byte per transaction
  task automatic write_reg(input logic [6:0] a, input logic [7:0] sub,
                           input logic [7:0] data,
                           output logic [2:0] acks);
    start_cond();
    send_byte({a, 1'b0}, acks[2]);
    send_byte(sub, acks[1]);
    send_byte(data, acks[0]);
    stop_cond();
  endtask : write_reg

  // Pointer phase ended by stop, then a one-byte read ended by a NACK
  task automatic read_reg(input logic [6:0] a, input logic [7:0] sub,
                          output logic [2:0] acks);
    logic [7:0] d;
    start_cond();
    send_byte({a, 1'b0}, acks[2]);
    send_byte(sub, acks[1]);
    stop_cond();
    start_cond();
    send_byte({a, 1'b1}, acks[0]);
    recv_byte(1'b1, d);
    stop_cond();
    rd_data_o  <= d;
    rd_valid_o <= 1'b1;
    wait_lnk(1);
    rd_valid_o <= 1'b0;
  endtask : read_reg
endmodule : vbuf_i2c_master_model

`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the video buffer two-wire control block
`timescale 1ns/1ps
`default_nettype none

module testbench;

  logic core_clk_i, reset_i, link_clk, scl, m_sda, sda_wire, sda_o, sda_oe;
  logic a_hi, a_lo, strap, rd_valid, sync_en, vsync_b, hsync_b;
  logic [7:0] rd_data;
  logic [2:0] mon_en, buf_en, mute, mux_b, filt_w, acks;
  logic [8:0] in_mode;
  logic [7:0] regs [1:4];
  logic [7:0] exp_q [$];
  int         n_fail, n_compared;
  int         seed;

  assign sda_wire = (sda_oe ? sda_o : 1'b1) & m_sda;

  vbuf_i2c_ctrl u_vbuf_i2c_ctrl (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .link_clk_i(link_clk),
    .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .addr_select_high_pin_i(a_hi), .addr_select_low_pin_i(a_lo),
    .power_up_state_strap_i(strap), .monitor_en_o(mon_en),
    .buffer_en_o(buf_en), .mute_o(mute), .mux_input_b_o(mux_b),
    .clamp_filter_wide_o(filt_w), .input_mode_o(in_mode),
    .vsync_input_b_o(vsync_b), .hsync_input_b_o(hsync_b),
    .sync_en_o(sync_en));

  vbuf_i2c_master_model u_vbuf_i2c_master_model (
    .link_clk_i(link_clk), .sda_i(sda_wire), .scl_o(scl), .sda_o(m_sda),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #7.5 link_clk = ~link_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // Read results are matched against the oldest expectation
  always @(posedge link_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check(rd_data, exp_q.pop_front());
    end
  end

  task automatic check_outputs;
    logic [2:0] m;
    logic       on;
    for (int c = 0; c < 3; c++) begin
      m  = regs[c+1][2:0];
      on = (m >= 3'h2);
      check(mon_en[c], on & !regs[4][6]);
      check(buf_en[c], on & !regs[4][5]);
      check(mute[c], m == 3'h1);
      check(mux_b[c], regs[c+1][6:3] inside {[4'h5:4'h9]});
      check(filt_w[c], regs[c+1][7] & (m >= 3'h5));
      check(in_mode[3*c +: 3], m);
    end
    check(vsync_b, regs[4][4:3] == 2'h1);
    check(hsync_b, regs[4][2:1] == 2'h1);
    check(sync_en, regs[4][0]);
  endtask : check_outputs

  task automatic do_reset(input logic s);
    @(posedge core_clk_i);
    strap   <= s;
    reset_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (10) @(posedge link_clk);
    for (int r = 1; r < 4; r++) regs[r] = s ? 8'h04 : 8'h00;
    regs[4] = s ? 8'h20 : 8'h60;
    check_outputs();
  endtask : do_reset

  task automatic do_write(input logic [7:0] sub, input logic [7:0] data);
    u_vbuf_i2c_master_model.write_reg({5'h0b, a_hi, a_lo}, sub, data, acks);
    check(acks, 3'h7);
    if (sub >= 8'h01 && sub <= 8'h04) regs[sub[2:0]] = data;
    repeat (20) @(posedge core_clk_i);
    check_outputs();
  endtask : do_write

  task automatic do_read(input logic [7:0] sub);
    exp_q.push_back((sub >= 8'h01 && sub <= 8'h04) ? regs[sub[2:0]] : 8'h00);
    u_vbuf_i2c_master_model.read_reg({5'h0b, a_hi, a_lo}, sub, acks);
    check(acks, 3'h7);
    repeat (4) @(posedge link_clk);
  endtask : do_read

  initial begin
    logic       ack;
    logic [7:0] d;
    n_fail     = 0;
    n_compared = 0;
    seed       = 32'h3c03756c;
    reset_i    = 1'b1;
    strap      = 1'b0;
    a_hi       = 1'b0;
    a_lo       = 1'b0;
    do_reset(1'b0);
    do_reset(1'b1);
    for (int r = 1; r <= 4; r++) do_read(r[7:0]);
    check_outputs();
    // Live select pins, and a near-miss address left unacknowledged
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk_i);
      {a_hi, a_lo} <= k[1:0];
      repeat (10) @(posedge link_clk);
      u_vbuf_i2c_master_model.start_cond();
      u_vbuf_i2c_master_model.send_byte({5'h0b, ~k[1:0], 1'b0}, ack);
      check(ack, 1'b0);
      u_vbuf_i2c_master_model.stop_cond();
      d = $random(seed);
      do_write(8'h01, d);
    end
    for (int m = 0; m < 8; m++) begin
      d = $random(seed);
      do_write(8'h01 + m % 3, {d[7:3], m[2:0]});
    end
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      do_write(8'h01 + i % 4, d);
      do_read(8'h01 + i % 4);
    end
    do_write(8'h00, 8'h5a);
    do_read(8'h00);
    // A fourth byte in one write is refused
    u_vbuf_i2c_master_model.start_cond();
    u_vbuf_i2c_master_model.send_byte({5'h0b, a_hi, a_lo, 1'b0}, ack);
    u_vbuf_i2c_master_model.send_byte(8'h02, ack);
    u_vbuf_i2c_master_model.send_byte(8'h33, ack);
    u_vbuf_i2c_master_model.send_byte(8'h44, ack);
    check(ack, 1'b0);
    u_vbuf_i2c_master_model.stop_cond();
    do_write(8'h02, 8'h2f);
    do_reset(1'b0);
    stop_test();
  end

  initial begin
    #800000;
    n_fail++;
    stop_test();
  end
endmodule : testbench

`default_nettype wire
